/* File: rtl/fswg_map.vh */
// Constants of the serial flash status and write-enable gate.
// Assumes inclusion by the gate module only; holds definitions and nothing else.
`ifndef FSWG_MAP_VH
`define FSWG_MAP_VH

// Status register field positions.
`define FSWG_SR_BUSY        0
`define FSWG_SR_WEN         1
`define FSWG_SR_BP_LSB      2
`define FSWG_SR_BP_MSB      5
`define FSWG_SR_QUAD        6
`define FSWG_SR_LOCK        7

// Reset value of the status register and of its non-volatile part.
`define FSWG_SR_RESET       8'h00
`define FSWG_NV_RESET       6'h00

// Address space layout: 21 address bits, 4 KB sectors, 32 KB and 64 KB blocks.
`define FSWG_ADDR_W         21
`define FSWG_SECTOR_LSB     12
`define FSWG_BLK32_LSB      15
`define FSWG_BLK64_LSB      16

// Instruction codes handled by the gate.
`define FSWG_OP_WRITE_STATUS    8'h01
`define FSWG_OP_PAGE_PROGRAM    8'h02
`define FSWG_OP_WRITE_DISABLE   8'h04
`define FSWG_OP_READ_STATUS     8'h05
`define FSWG_OP_WRITE_ENABLE    8'h06
`define FSWG_OP_AUTOBOOT_WRITE  8'h15
`define FSWG_OP_SECTOR_ERASE_A  8'h20
`define FSWG_OP_QUAD_PROGRAM_A  8'h32
`define FSWG_OP_QUAD_PROGRAM_B  8'h38
`define FSWG_OP_FUNC_WRITE      8'h42
`define FSWG_OP_HALF_BLK_ERASE  8'h52
`define FSWG_OP_CHIP_ERASE_A    8'h60
`define FSWG_OP_INFO_PROGRAM    8'h62
`define FSWG_OP_INFO_ERASE      8'h64
`define FSWG_OP_RDPARAM_NV_WR   8'h65
`define FSWG_OP_EXT_RDPARAM_NV  8'h85
`define FSWG_OP_CHIP_ERASE_B    8'hC7
`define FSWG_OP_SECTOR_ERASE_B  8'hD7
`define FSWG_OP_BLOCK_ERASE     8'hD8

// Bit counts of a complete frame for each instruction shape.
`define FSWG_LEN_OPCODE     6'h08
`define FSWG_LEN_ONE_BYTE   6'h10
`define FSWG_LEN_ADDR       6'h20
`define FSWG_LEN_ADDR_DATA  6'h28
`define FSWG_CNT_MAX        6'h3F

`endif

/* File: rtl/fswg_gate.v */
// Status register, write enable latch and busy gating of a serial flash.
// Assumes a mode 0 or mode 3 serial master; all pins are asynchronous to i_clk
// and the serial clock is several times slower than i_clk.
`timescale 1ns/1ps
`include "fswg_map.vh"

// Function
// - Uniform 4 KB sectors, 32/64 KB blocks.
// - Decode addresses to 1FFFFFh, sectors numbered ascending.
// - Register read repeats until chip select rises.
// - Eight-bit status register, fixed bit layout, zero default.
// - Busy flag is read-only, one means busy.
// - Busy during program, erase, nonvolatile writes.
// - While busy, ignore all but reads, reset, suspend of program or erase.
// - Latch set by enable, cleared by disable, reset or write end.
// - Latch clears when any write operation completes.
// - Write instructions inhibited while latch is zero.
// - Program and erase instructions need the latch.
// - Nonvolatile register writes need the latch too.
// - Volatile parameter sets run without the latch.
// - Protect, quad, lock bits nonvolatile, written by 01h.
// - Status read returns the whole status register.
// - Nonzero block protect bits mark blocks protected.
// - Quad enable bit switches the quad function.
// - Lock bit marks the status register protected.
// - Lock bit with protect pin low blocks status writes.
// - Sample on rising clock, drive on falling.
module fswg_gate #(
    parameter [7:0]  OP_READ_FUNC       = 8'h48,  // Function register read code.
    parameter [7:0]  OP_READ_EXT        = 8'h81,  // Extended read register read code.
    parameter [7:0]  OP_SOFT_RESET      = 8'h99,  // Software reset code.
    parameter [7:0]  OP_SUSPEND         = 8'h75,  // Program or erase suspend code.
    parameter [7:0]  OP_RDPARAM_VOL     = 8'hC0,  // Volatile read parameter set code.
    parameter [7:0]  OP_EXT_RDPARAM_VOL = 8'h83,  // Volatile extended parameter set code.
    parameter [15:0] ARRAY_BUSY_CYCLES  = 16'h0400, // Busy length of program or erase.
    parameter [15:0] REG_BUSY_CYCLES    = 16'h0100  // Busy length of a register write.
) (
    // Clock and reset.
    input  wire                      i_clk,
    input  wire                      i_rst_n,
    // Serial pins.
    input  wire                      i_sck,
    input  wire                      i_cs_n,
    input  wire                      i_si,
    input  wire                      i_wp_n,
    output reg                       o_so,
    output wire                      o_so_oe,
    // Accepted instruction towards the array logic.
    output reg                       o_cmd_valid,
    output reg  [7:0]                o_cmd_code,
    output reg  [`FSWG_ADDR_W-1:0]   o_cmd_addr,
    output reg  [8:0]                o_sector,
    output reg  [5:0]                o_block32,
    output reg  [4:0]                o_block64,
    // Status towards the rest of the device.
    output wire [7:0]                o_status,
    output wire                      o_busy,
    output wire                      o_quad_enable,
    output wire [3:0]                o_block_protect,
    output wire                      o_any_protected,
    output wire                      o_status_locked
);

    // Busy kinds: array operation or register write.
    localparam KIND_ARRAY = 1'b0;
    localparam KIND_REG   = 1'b1;

    // Three-stage synchronisers for each pin.
    reg  [2:0]  sck_sync_q;        // Serial clock stages.
    reg  [2:0]  cs_sync_q;         // Chip select stages.
    reg  [2:0]  si_sync_q;         // Serial data stages.
    reg  [2:0]  wp_sync_q;         // Write protect stages.
    reg         sck_f_q;           // Filtered serial clock.
    reg         cs_f_q;            // Filtered chip select, high when idle.
    reg         wp_f_q;            // Filtered write protect pin.

    // Frame state.
    reg  [5:0]  cnt_q;             // Bits taken in this frame, saturating.
    reg  [31:0] shift_q;           // Incoming bits, newest in bit 0.
    reg  [7:0]  op_q;              // Opcode of the current frame.
    reg  [7:0]  data_q;            // First byte after the opcode.
    reg  [`FSWG_ADDR_W-1:0] addr_q; // Address of the current frame.
    reg         reading_q;         // Status read in progress.
    reg  [2:0]  rd_idx_q;          // Next status bit to drive, from bit 7 down.

    // Status state.
    reg  [5:0]  nv_q;              // Lock, quad and protect bits.
    reg         wen_q;             // Write enable latch.
    reg         busy_q;            // Busy flag.
    reg         kind_q;            // Kind of the running operation.
    reg  [15:0] busy_cnt_q;        // Cycles left of the running operation.
    reg  [5:0]  nv_new_q;          // Value to store when a status write ends.

    // Filter outputs and edges.
    wire        sck_stable = (sck_sync_q[1] == sck_sync_q[2]);
    wire        sck_rise   = sck_stable && sck_sync_q[2] && !sck_f_q;
    wire        sck_fall   = sck_stable && !sck_sync_q[2] && sck_f_q;
    wire        cs_stable  = (cs_sync_q[1] == cs_sync_q[2]);
    wire        cs_rise    = cs_stable && cs_sync_q[2] && !cs_f_q;
    wire        selected   = !cs_f_q;
    wire        rise_act   = sck_rise && selected;
    wire [31:0] shift_d    = {shift_q[30:0], si_sync_q[2]};

    // Status bits as seen by the host.
    assign o_status        = {nv_q, wen_q, busy_q};
    assign o_busy          = busy_q;
    assign o_quad_enable   = nv_q[`FSWG_SR_QUAD-2];
    assign o_block_protect = nv_q[`FSWG_SR_BP_MSB-2:0];
    assign o_any_protected = |nv_q[`FSWG_SR_BP_MSB-2:0];
    assign o_status_locked = nv_q[`FSWG_SR_LOCK-2];
    assign o_so_oe         = reading_q && selected;

    // Instruction classes.
    reg         needs_wen;         // Program, erase or nonvolatile write.
    reg         is_array;          // Operation that touches the array.
    reg         len_ok;            // Frame length fits the instruction.
    reg         allowed_busy;      // May run while busy.
    reg         is_volatile;       // Volatile parameter set.
    wire        sr_write_blocked = o_status_locked && !wp_f_q;

    // Classify the latched opcode for the execution at chip select rise.
    always @* begin
        needs_wen    = 1'b0;
        is_array     = 1'b0;
        len_ok       = (cnt_q >= `FSWG_LEN_ONE_BYTE);
        case (op_q)
            `FSWG_OP_PAGE_PROGRAM, `FSWG_OP_QUAD_PROGRAM_A,
            `FSWG_OP_QUAD_PROGRAM_B: begin
                needs_wen = 1'b1;
                is_array  = 1'b1;
                len_ok    = (cnt_q >= `FSWG_LEN_ADDR_DATA);
            end
            `FSWG_OP_SECTOR_ERASE_A, `FSWG_OP_SECTOR_ERASE_B,
            `FSWG_OP_HALF_BLK_ERASE, `FSWG_OP_BLOCK_ERASE: begin
                needs_wen = 1'b1;
                is_array  = 1'b1;
                len_ok    = (cnt_q == `FSWG_LEN_ADDR);
            end
            `FSWG_OP_CHIP_ERASE_A, `FSWG_OP_CHIP_ERASE_B: begin
                // Chip erase also requires every block unprotected.
                needs_wen = 1'b1;
                is_array  = 1'b1;
                len_ok    = (cnt_q == `FSWG_LEN_OPCODE) && !o_any_protected;
            end
            `FSWG_OP_WRITE_STATUS, `FSWG_OP_FUNC_WRITE, `FSWG_OP_RDPARAM_NV_WR,
            `FSWG_OP_EXT_RDPARAM_NV, `FSWG_OP_INFO_ERASE, `FSWG_OP_INFO_PROGRAM,
            `FSWG_OP_AUTOBOOT_WRITE: begin
                needs_wen = 1'b1;
            end
            default: begin
                len_ok    = (cnt_q >= `FSWG_LEN_OPCODE);
            end
        endcase
        // Only status, function and read register reads, reset, and suspend of an array operation pass a busy device.
        allowed_busy = (op_q == `FSWG_OP_READ_STATUS) || (op_q == OP_READ_FUNC) ||
                       (op_q == OP_READ_EXT) || (op_q == OP_SOFT_RESET) ||
                       ((op_q == OP_SUSPEND) && (kind_q == KIND_ARRAY));
        is_volatile  = (op_q == OP_RDPARAM_VOL) || (op_q == OP_EXT_RDPARAM_VOL);
    end

    // Pin synchronisers and glitch filters; a level counts once stages two and three agree.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_sync_q <= 3'h0;
            cs_sync_q  <= 3'h7;
            si_sync_q  <= 3'h0;
            wp_sync_q  <= 3'h7;
            sck_f_q    <= 1'b0;
            cs_f_q     <= 1'b1;
            wp_f_q     <= 1'b1;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], i_sck};
            cs_sync_q  <= {cs_sync_q[1:0], i_cs_n};
            si_sync_q  <= {si_sync_q[1:0], i_si};
            wp_sync_q  <= {wp_sync_q[1:0], i_wp_n};
            if (sck_stable) begin
                sck_f_q <= sck_sync_q[2];
            end
            if (cs_stable) begin
                cs_f_q <= cs_sync_q[2];
            end
            if (wp_sync_q[1] == wp_sync_q[2]) begin
                wp_f_q <= wp_sync_q[2];
            end
        end
    end

    // Frame receiver: bits taken on rising serial clock edges only.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q     <= 6'h00;
            shift_q   <= 32'h0000_0000;
            op_q      <= 8'h00;
            data_q    <= 8'h00;
            addr_q    <= {`FSWG_ADDR_W{1'b0}};
            reading_q <= 1'b0;
        end else if (!selected) begin
            // Idle: clear the frame so the next one starts from bit zero.
            cnt_q     <= 6'h00;
            reading_q <= 1'b0;
        end else if (rise_act) begin
            shift_q <= shift_d;
            if (cnt_q != `FSWG_CNT_MAX) begin
                cnt_q <= cnt_q + 6'h01;
            end
            if (cnt_q == `FSWG_LEN_OPCODE - 6'h01) begin
                op_q      <= shift_d[7:0];
                reading_q <= (shift_d[7:0] == `FSWG_OP_READ_STATUS);
            end
            if (cnt_q == `FSWG_LEN_ONE_BYTE - 6'h01) begin
                data_q <= shift_d[7:0];
            end
            if (cnt_q == `FSWG_LEN_ADDR - 6'h01) begin
                // Upper address bits beyond the 2 MB space are dropped.
                addr_q <= shift_d[`FSWG_ADDR_W-1:0];
            end
        end
    end

    // Status output: live status, bit 7 first, updated on falling edges, wrapping each byte.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_so     <= 1'b0;
            rd_idx_q <= 3'h0;
        end else if (!reading_q) begin
            rd_idx_q <= 3'h0;
        end else if (sck_fall && selected) begin
            // The index wraps after bit 0, so the register repeats while selected.
            o_so     <= o_status[3'h7 - rd_idx_q];
            rd_idx_q <= rd_idx_q + 3'h1;
        end
    end

    // Execution at chip select rise, busy timing and latch control.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nv_q        <= `FSWG_NV_RESET;
            wen_q       <= 1'b0;
            busy_q      <= 1'b0;
            kind_q      <= KIND_ARRAY;
            busy_cnt_q  <= 16'h0000;
            nv_new_q    <= `FSWG_NV_RESET;
            o_cmd_valid <= 1'b0;
            o_cmd_code  <= 8'h00;
            o_cmd_addr  <= {`FSWG_ADDR_W{1'b0}};
            o_sector    <= 9'h000;
            o_block32   <= 6'h00;
            o_block64   <= 5'h00;
        end else begin
            o_cmd_valid <= 1'b0;
            if (busy_q) begin
                if (busy_cnt_q == 16'h0001) begin
                    // End of operation: store status bits of a register write, drop busy and the latch.
                    busy_q <= 1'b0;
                    wen_q  <= 1'b0;
                    if (kind_q == KIND_REG) begin
                        nv_q <= nv_new_q;
                    end
                end
                busy_cnt_q <= busy_cnt_q - 16'h0001;
            end
            if (cs_rise && (cnt_q != 6'h00) && (!busy_q || allowed_busy)) begin
                if (op_q == OP_SOFT_RESET) begin
                    // Software reset aborts the operation; stored bits stay.
                    busy_q      <= 1'b0;
                    wen_q       <= 1'b0;
                    busy_cnt_q  <= 16'h0000;
                    o_cmd_valid <= 1'b1;
                    o_cmd_code  <= op_q;
                end else if ((op_q == `FSWG_OP_WRITE_ENABLE) ||
                             (op_q == `FSWG_OP_WRITE_DISABLE)) begin
                    // Latch commands are reported too, so the array side sees them.
                    if (cnt_q == `FSWG_LEN_OPCODE) begin
                        wen_q       <= (op_q == `FSWG_OP_WRITE_ENABLE);
                        o_cmd_valid <= 1'b1;
                        o_cmd_code  <= op_q;
                    end
                end else if (needs_wen) begin
                    // Without the latch the instruction is dropped silently.
                    if (wen_q && len_ok && !((op_q == `FSWG_OP_WRITE_STATUS)
                                             && sr_write_blocked)) begin
                        busy_q      <= 1'b1;
                        kind_q      <= is_array ? KIND_ARRAY : KIND_REG;
                        busy_cnt_q  <= is_array ? ARRAY_BUSY_CYCLES : REG_BUSY_CYCLES;
                        // The latch bit of the written byte is ignored here.
                        nv_new_q    <= (op_q == `FSWG_OP_WRITE_STATUS) ?
                                       data_q[7:2] : nv_q;
                        o_cmd_valid <= 1'b1;
                        o_cmd_code  <= op_q;
                        o_cmd_addr  <= addr_q;
                        o_sector    <= addr_q[`FSWG_ADDR_W-1:`FSWG_SECTOR_LSB];
                        o_block32   <= addr_q[`FSWG_ADDR_W-1:`FSWG_BLK32_LSB];
                        o_block64   <= addr_q[`FSWG_ADDR_W-1:`FSWG_BLK64_LSB];
                    end
                end else if (len_ok && (op_q != `FSWG_OP_READ_STATUS)) begin
                    // Volatile sets, other reads and suspend pass straight on.
                    o_cmd_valid <= 1'b1;
                    o_cmd_code  <= op_q;
                    o_cmd_addr  <= addr_q;
                    if (is_volatile) begin
                        o_cmd_addr <= {{(`FSWG_ADDR_W-8){1'b0}}, data_q};
                    end
                end
            end
        end
    end

endmodule

/* File: dv/fswg_gate_chk.sv */
// Port checks of the flash status and write-enable gate.
// Assumes binding into fswg_gate; busy lengths follow its parameters.
`timescale 1ns/1ps
module fswg_gate_chk #(
    parameter [15:0] ARRAY_BUSY_CYCLES = 16'h0400,  // Busy length of program or erase.
    parameter [15:0] REG_BUSY_CYCLES   = 16'h0100   // Busy length of a register write.
) (
    // Clock, reset and protect pin.
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_wp_n,
    // Accepted instruction.
    input wire        o_cmd_valid,
    input wire [7:0]  o_cmd_code,
    input wire [20:0] o_cmd_addr,
    input wire [8:0]  o_sector,
    input wire [5:0]  o_block32,
    input wire [4:0]  o_block64,
    // Status outputs.
    input wire [7:0]  o_status,
    input wire        o_busy,
    input wire        o_quad_enable,
    input wire [3:0]  o_block_protect,
    input wire        o_any_protected,
    input wire        o_status_locked
);
    reg  [15:0] busy_cnt_q;                                  // Cycles busy has been high.
    wire [15:0] busy_cnt_d = o_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    wire        len_ok = (busy_cnt_q + 16'h0001 >= REG_BUSY_CYCLES
                         && busy_cnt_q <= REG_BUSY_CYCLES + 16'h0001)
                         || (busy_cnt_q + 16'h0001 >= ARRAY_BUSY_CYCLES
                         && busy_cnt_q <= ARRAY_BUSY_CYCLES + 16'h0001);
    wire        gated = o_cmd_valid && (o_cmd_code inside {8'h01, 8'h02, 8'h32, 8'h38,
                        8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h65, 8'h85,
                        8'h64, 8'h62, 8'h15});
    // Counts busy cycles so that the length of each write can be judged.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_status_map;
        o_status == {o_status_locked, o_quad_enable, o_block_protect, o_status[1], o_busy}
            && o_any_protected == (|o_block_protect);
    endproperty
    a_status_map: assert property (p_status_map)
        else $error("status fields disagree");
    property p_busy_on_write;
        gated |-> ##[0:1] o_busy;
    endproperty
    a_busy_on_write: assert property (p_busy_on_write)
        else $error("accepted write did not raise busy");
    property p_busy_len;
        $fell(o_busy) && o_cmd_code != 8'h99 |-> len_ok && !o_status[1];
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong or latch left set");
    property p_wel_set;
        $rose(o_status[1]) |-> ##[0:2] (o_cmd_code == 8'h06);
    endproperty
    a_wel_set: assert property (p_wel_set)
        else $error("latch set without enable command");
    property p_wel_clear;
        $fell(o_status[1]) |-> $fell(o_busy) or ##[0:2] (o_cmd_code inside {8'h04, 8'h99});
    endproperty
    a_wel_clear: assert property (p_wel_clear)
        else $error("latch cleared without cause");
    property p_busy_ignore;
        o_cmd_valid && $past(o_busy) |-> o_cmd_code inside {8'h05, 8'h48, 8'h81, 8'h99, 8'h75};
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("instruction accepted while busy");
    property p_gated_wel;
        gated |-> $past(o_status[1]);
    endproperty
    a_gated_wel: assert property (p_gated_wel)
        else $error("write accepted with latch clear");
    property p_lock;
        o_cmd_valid && o_cmd_code == 8'h01 |-> !$past(o_status_locked) || $past(i_wp_n);
    endproperty
    a_lock: assert property (p_lock)
        else $error("status write accepted while locked");
    property p_sector;
        o_cmd_valid && (o_cmd_code inside {8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8})
            |-> o_sector == o_cmd_addr[20:12] && o_block32 == o_cmd_addr[20:15]
            && o_block64 == o_cmd_addr[20:16];
    endproperty
    a_sector: assert property (p_sector)
        else $error("sector or block number wrong");
    property p_nv_stable;
        !$stable(o_status[7:2]) |-> $fell(o_busy);
    endproperty
    a_nv_stable: assert property (p_nv_stable)
        else $error("nonvolatile bits changed outside a write end");
    c_busy_done: cover property ($fell(o_busy));
    c_latch_set: cover property ($rose(o_status[1]));
    c_locked: cover property (o_status_locked && !i_wp_n && o_status[1]);
endmodule
bind fswg_gate fswg_gate_chk #(
    .ARRAY_BUSY_CYCLES (ARRAY_BUSY_CYCLES),
    .REG_BUSY_CYCLES   (REG_BUSY_CYCLES)
) fswg_gate_chk_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wp_n(i_wp_n), .o_cmd_valid(o_cmd_valid),
    .o_cmd_code(o_cmd_code), .o_cmd_addr(o_cmd_addr), .o_sector(o_sector),
    .o_block32(o_block32), .o_block64(o_block64), .o_status(o_status), .o_busy(o_busy),
    .o_quad_enable(o_quad_enable), .o_block_protect(o_block_protect),
    .o_any_protected(o_any_protected), .o_status_locked(o_status_locked)
);

/* File: dv/fswg_host.sv */
// Serial host model clocking mode 0 frames into the gate.
// Assumes a 50 ns bench clock; the serial clock runs at 400 ns inside frames only.
`timescale 1ns/1ps
module fswg_host (
    // Bench clock.
    input  wire  i_clk,
    // Serial pins.
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input  wire  i_so
);
    // Idle pins: deselected, clock low.
    initial begin
        o_sck  = 1'h0;
        o_cs_n = 1'h1;
        o_si   = 1'h0;
    end
    // Sends the n leading bits of d, MSB first; rd keeps the last 16 bits read.
    task automatic xfer(input logic [39:0] d, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge i_clk);
        o_cs_n <= 1'h0;
        for (int b = 0; b < n; b++) begin
            o_sck <= 1'h0;
            o_si  <= d[39-b];
            repeat (4) @(posedge i_clk);
            o_sck <= 1'h1;
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            rd = {rd[14:0], i_so};
            @(posedge i_clk);
        end
        o_sck <= 1'h0;
        o_si  <= ~o_si;  // A released line shows the inverse of its last bit.
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'h1;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench of the flash status and write-enable gate.
// Assumes the host model drives the serial pins; both busy lengths set to 600.
`timescale 1ns/1ps
module tb_top;
    logic        i_clk   = 1'h0;          // Bench clock.
    logic        i_rst_n = 1'h0;          // Asynchronous reset.
    logic        i_wp_n  = 1'h1;          // Write protect pin.
    wire         i_sck, i_cs_n, i_si, o_so, o_so_oe, o_cmd_valid, o_busy;
    wire         o_quad_enable, o_any_protected, o_status_locked;
    wire  [7:0]  o_cmd_code, o_status;
    wire  [20:0] o_cmd_addr;
    wire  [8:0]  o_sector;
    wire  [5:0]  o_block32;
    wire  [4:0]  o_block64;
    wire  [3:0]  o_block_protect;
    int          err_total = 0, compares = 0, acc_n = 0, n0;
    logic [7:0]  acc_code;                // Code of the last accepted instruction.
    logic [19:0] acc_sec;                 // Sector and block numbers seen with it.
    logic [5:0]  m_nv = 6'h00;            // Model of status bits 7:2.
    logic        m_wen = 1'h0;            // Model of the write enable latch.
    logic [31:0] seed = 32'h0001_11C4;    // Random state.
    logic [15:0] rd;                      // Bits read back by the last frame.
    // Gated codes: opcode, frame length, sector check.
    logic [14:0] ops [$] = '{{8'h02, 6'h28, 1'h1}, {8'h32, 6'h28, 1'h1}, {8'h38, 6'h28, 1'h1},
        {8'hD7, 6'h20, 1'h1}, {8'h20, 6'h20, 1'h1}, {8'h52, 6'h20, 1'h1}, {8'hD8, 6'h20, 1'h1},
        {8'hC7, 6'h08, 1'h0}, {8'h60, 6'h08, 1'h0}, {8'h42, 6'h28, 1'h0}, {8'h65, 6'h28, 1'h0},
        {8'h85, 6'h28, 1'h0}, {8'h64, 6'h20, 1'h0}, {8'h62, 6'h28, 1'h0}, {8'h15, 6'h28, 1'h0}};
    logic [7:0]  vol [$] = '{8'hC0, 8'h83};  // Volatile parameter set codes.
    fswg_gate #(
        .ARRAY_BUSY_CYCLES (16'h0258),
        .REG_BUSY_CYCLES   (16'h0258)
    ) fswg_gate_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
        .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_cmd_valid(o_cmd_valid),
        .o_cmd_code(o_cmd_code), .o_cmd_addr(o_cmd_addr), .o_sector(o_sector),
        .o_block32(o_block32), .o_block64(o_block64), .o_status(o_status), .o_busy(o_busy),
        .o_quad_enable(o_quad_enable), .o_block_protect(o_block_protect),
        .o_any_protected(o_any_protected), .o_status_locked(o_status_locked)
    );
    fswg_host fswg_host_inst (
        .i_clk(i_clk), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so)
    );
    initial forever #25 i_clk = ~i_clk;
    // Records every accepted instruction pulse.
    always @(posedge i_clk) begin
        if (o_cmd_valid === 1'h1) begin
            acc_n    <= acc_n + 1;
            acc_code <= o_cmd_code;
            acc_sec  <= {o_sector, o_block32, o_block64};
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] sr(input logic busy);
        return {m_nv, m_wen, busy};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] op, input int n, input logic [31:0] arg);
        fswg_host_inst.xfer({op, arg}, n, rd);
    endtask
    task automatic write_enable_cmd;
        send(8'h06, 8, 32'h0000_0000);
        m_wen = 1'h1;
    endtask
    // Polls the status register until the write ends, then models the latch clear.
    task automatic wait_idle;
        for (int i = 0; i < 20; i++) begin
            send(8'h05, 16, 32'h0000_0000);
            if (rd[0] === 1'h0) begin
                m_wen = 1'h0;
                return;
            end
        end
        err_total++;
        test_done();
    endtask
    task automatic test_done;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_clk);
        err_total++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'h1;
        repeat (6) @(posedge i_clk);
        chk(o_status, sr(1'h0));
        send(8'h02, 40, 32'h0001_00A5);  // Program with the latch still clear.
        chk(acc_n, 0);
        foreach (ops[i]) begin
            seed = lfsr(seed);
            write_enable_cmd();
            chk(o_status, sr(1'h0));
            n0 = acc_n;
            send(ops[i][14:7], ops[i][6:1], {3'h0, seed[20:0], 8'hA5});
            chk(acc_n, n0 + 1);
            chk(acc_code, ops[i][14:7]);
            if (ops[i][0]) chk(acc_sec, {seed[20:12], seed[20:15], seed[20:16]});
            send(8'h04, 8, 32'h0000_0000);  // Disable while busy must be dropped.
            send(8'h05, 16, 32'h0000_0000);
            chk(rd[7:0], sr(1'h1));
            wait_idle();
            chk(o_status, sr(1'h0));
        end
        write_enable_cmd();
        send(8'h01, 16, 32'h7F00_0000);
        m_nv = 6'h1F;
        wait_idle();
        chk(o_status, sr(1'h0));
        chk({o_quad_enable, o_block_protect, o_any_protected,
             o_status_locked}, 7'h7E);
        send(8'h05, 24, 32'h0000_0000);
        chk(rd, {sr(1'h0), sr(1'h0)});
        write_enable_cmd();
        n0 = acc_n;
        send(8'hC7, 8, 32'h0000_0000);  // Chip erase with protected blocks.
        chk(acc_n, n0);
        send(8'h04, 8, 32'h0000_0000);
        m_wen = 1'h0;
        chk(o_status, sr(1'h0));
        write_enable_cmd();
        send(8'h01, 16, 32'h8000_0000);
        m_nv = 6'h20;
        wait_idle();
        chk(o_status, sr(1'h0));
        i_wp_n <= 1'h0;
        write_enable_cmd();
        send(8'h01, 16, 32'h0000_0000);  // Locked and protect pin low: dropped.
        repeat (20) @(posedge i_clk);
        chk(o_status, sr(1'h0));
        i_wp_n <= 1'h1;
        send(8'h01, 16, 32'h0000_0000);
        m_nv = 6'h00;
        wait_idle();
        chk(o_status, sr(1'h0));
        foreach (vol[i]) begin
            n0 = acc_n;
            send(vol[i], 16, 32'h5A00_0000);
            chk(acc_n, n0 + 1);
            chk(acc_code, vol[i]);
            chk(o_cmd_addr, 8'h5A);
        end
        test_done();
    end
endmodule
